// *** core/cmpc_regs.sv ***
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
// Register bank for two comparators with interrupt status and mask
module cmpc_regs
  import cmpc_pkg::*;
(
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         clk_en_i,
  input  wire logic [ADDR_W-1:0]            addr_i,
  input  wire logic [7:0]                   wdata_i,
  input  wire logic                         wr_i,
  input  wire logic                         rd_i,
  output logic [7:0]                        rdata_o,
  input  wire logic [NUM_CMP-1:0]           raw_i,
  input  wire logic                         tmr_clk_i,
  output logic [NUM_CMP-1:0]                enable_o,
  output logic [NUM_CMP-1:0]                hyst_o,
  output logic [NUM_CMP*NEG_SRC_N-1:0]      neg_route_o,
  output logic [NUM_CMP*POS_SRC_N-1:0]      pos_route_o,
  output logic [NUM_CMP-1:0]                sync_out_o,
  output logic                              irq_o
);
  logic [7:0]         con0 [NUM_CMP];
  logic [7:0]         con1 [NUM_CMP];
  logic [2:0]         nsel [NUM_CMP];
  logic [2:0]         psel [NUM_CMP];
  logic [NUM_CMP-1:0] result;
  logic [NUM_CMP-1:0] flag;
  logic [NUM_CMP-1:0] flag_clr;
  logic [NUM_CMP-1:0] irq_mask;
  logic [7:0]         next_rdata;

  // Address of a per-comparator register
  function automatic logic [ADDR_W-1:0] cmp_addr(input int idx, input logic [4:0] off);
    cmp_addr = ADDR_W'(idx * int'(CMP_STRIDE)) + off;
  endfunction

  // Write-one-to-clear on the status register
  assign flag_clr = (wr_i && addr_i == OFF_IRQ_STATUS) ? wdata_i[NUM_CMP-1:0] : '0;

  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g++) begin : g_cmp
      // Writable control fields, unimplemented bits held at zero
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          con0[g] <= REG_RESET;
          con1[g] <= REG_RESET;
          nsel[g] <= '0;
          psel[g] <= '0;
        end else if (clk_en_i && wr_i) begin
          if (addr_i == cmp_addr(g, OFF_CON0)) begin
            con0[g] <= wdata_i & CON0_WMASK;
          end
          if (addr_i == cmp_addr(g, OFF_CON1)) begin
            con1[g] <= wdata_i & CON1_WMASK;
          end
          if (addr_i == cmp_addr(g, OFF_NSEL)) begin
            nsel[g] <= wdata_i[2:0];
          end
          if (addr_i == cmp_addr(g, OFF_PSEL)) begin
            psel[g] <= wdata_i[2:0];
          end
        end
      end

      cmpc_unit u_unit (
        .ref_clk_i   (ref_clk_i),
        .rst_n_i     (rst_n_i),
        .clk_en_i    (clk_en_i),
        .con0_i      (con0[g]),
        .con1_i      (con1[g]),
        .nsel_i      (nsel[g]),
        .psel_i      (psel[g]),
        .raw_i       (raw_i[g]),
        .tmr_clk_i   (tmr_clk_i),
        .flag_clr_i  (flag_clr[g] & clk_en_i),
        .result_o    (result[g]),
        .irq_flag_o  (flag[g]),
        .neg_route_o (neg_route_o[g*NEG_SRC_N +: NEG_SRC_N]),
        .pos_route_o (pos_route_o[g*POS_SRC_N +: POS_SRC_N]),
        .sync_out_o  (sync_out_o[g])
      );

      // Analog enable and hysteresis straight from flops
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          enable_o[g] <= 1'b0;
          hyst_o[g]   <= 1'b0;
        end else if (clk_en_i) begin
          enable_o[g] <= con0[g][CON0_ON_BIT];
          hyst_o[g]   <= con0[g][CON0_HYS_BIT];
        end
      end
    end
  endgenerate

  // Interrupt mask register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask <= '0;
    end else if (clk_en_i && wr_i && addr_i == OFF_IRQ_MASK) begin
      irq_mask <= wdata_i[NUM_CMP-1:0];
    end
  end

  // Level interrupt output
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      irq_o <= |(flag & irq_mask);
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    for (int i = 0; i < NUM_CMP; i++) begin
      if (addr_i == cmp_addr(i, OFF_CON0)) begin
        next_rdata = con0[i];
        next_rdata[CON0_OUT_BIT] = result[i];
      end
      if (addr_i == cmp_addr(i, OFF_CON1)) begin
        next_rdata = con1[i];
      end
      if (addr_i == cmp_addr(i, OFF_NSEL)) begin
        next_rdata = {5'h00, nsel[i]};
      end
      if (addr_i == cmp_addr(i, OFF_PSEL)) begin
        next_rdata = {5'h00, psel[i]};
      end
    end
    if (addr_i == OFF_MIRROR) begin
      next_rdata = {6'h00, result};
    end
    if (addr_i == OFF_IRQ_STATUS) begin
      next_rdata = {6'h00, flag};
    end
    if (addr_i == OFF_IRQ_MASK) begin
      next_rdata = {6'h00, irq_mask};
    end
  end

  // Read data valid the cycle after the strobe only
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      rdata_o <= rd_i ? next_rdata : 8'h00;
    end
  end
endmodule

// *** core/cmpc_pkg.sv ***
package cmpc_pkg;
  localparam int          ADDR_W          = 5;
  localparam int          NUM_CMP         = 2;
  // Register offsets, comparator n at base + n*CMP_STRIDE; mirror, status and mask at fixed addresses
  localparam logic [4:0]  CMP_STRIDE      = 5'h04;
  localparam logic [4:0]  OFF_CON0        = 5'h00;
  localparam logic [4:0]  OFF_CON1        = 5'h01;
  localparam logic [4:0]  OFF_NSEL        = 5'h02;
  localparam logic [4:0]  OFF_PSEL        = 5'h03;
  localparam logic [4:0]  OFF_MIRROR      = 5'h10;
  localparam logic [4:0]  OFF_IRQ_STATUS  = 5'h11;
  localparam logic [4:0]  OFF_IRQ_MASK    = 5'h12;
  // Control register 0 fields
  localparam int          CON0_SYNC_BIT   = 0;
  localparam int          CON0_HYS_BIT    = 1;
  localparam int          CON0_POL_BIT    = 4;
  localparam int          CON0_OUT_BIT    = 6;
  localparam int          CON0_ON_BIT     = 7;
  localparam logic [7:0]  CON0_WMASK      = 8'h93;
  // Edge enable fields
  localparam int          CON1_FALL_BIT   = 0;
  localparam int          CON1_RISE_BIT   = 1;
  localparam logic [7:0]  CON1_WMASK      = 8'h03;
  localparam logic [7:0]  SEL_WMASK       = 8'h07;
  localparam logic [7:0]  REG_RESET       = 8'h00;
  // Input routing one-hot widths
  localparam int          NEG_SRC_N       = 6;
  localparam int          POS_SRC_N       = 5;
endpackage

// *** core/cmpc_unit.sv ***
`timescale 1ns/1ps
// One comparator channel: routing decode, polarity, edge flags, sync output
module cmpc_unit
  import cmpc_pkg::*;
(
  input  wire logic                 ref_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic                 clk_en_i,
  input  wire logic [7:0]           con0_i,
  input  wire logic [7:0]           con1_i,
  input  wire logic [2:0]           nsel_i,
  input  wire logic [2:0]           psel_i,
  input  wire logic                 raw_i,
  input  wire logic                 tmr_clk_i,
  input  wire logic                 flag_clr_i,
  output logic                      result_o,
  output logic                      irq_flag_o,
  output logic [NEG_SRC_N-1:0]      neg_route_o,
  output logic [POS_SRC_N-1:0]      pos_route_o,
  output logic                      sync_out_o
);
  logic [1:0] raw_sync;
  logic [1:0] tmr_sync;
  logic       tmr_prev;
  logic       result;
  logic       result_prev;
  logic       rise_hit;
  logic       fall_hit;

  // Neg route: bits 0-3 pins, 4 reference buffer, 5 ground
  function automatic logic [NEG_SRC_N-1:0] neg_decode(input logic [2:0] code);
    case (code)
      3'h0: neg_decode = 6'h01;
      3'h1: neg_decode = 6'h02;
      3'h2: neg_decode = 6'h04;
      3'h3: neg_decode = 6'h08;
      3'h6: neg_decode = 6'h10;
      3'h7: neg_decode = 6'h20;
      default: neg_decode = 6'h00;
    endcase
  endfunction

  // Pos route: bits 0-1 pins, 2 DAC, 3 reference buffer, 4 ground
  function automatic logic [POS_SRC_N-1:0] pos_decode(input logic [2:0] code);
    case (code)
      3'h0: pos_decode = 5'h01;
      3'h1: pos_decode = 5'h02;
      3'h5: pos_decode = 5'h04;
      3'h6: pos_decode = 5'h08;
      3'h7: pos_decode = 5'h10;
      default: pos_decode = 5'h00;
    endcase
  endfunction

  // Registered routing selects
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      neg_route_o <= '0;
      pos_route_o <= '0;
    end else if (clk_en_i) begin
      neg_route_o <= neg_decode(nsel_i);
      pos_route_o <= pos_decode(psel_i);
    end
  end

  // Synchronise analog result and timer clock
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      raw_sync <= '0;
      tmr_sync <= '0;
      tmr_prev <= 1'b0;
    end else if (clk_en_i) begin
      raw_sync <= {raw_sync[0], raw_i};
      tmr_sync <= {tmr_sync[0], tmr_clk_i};
      tmr_prev <= tmr_sync[1];
    end
  end

  assign result   = raw_sync[1] ^ con0_i[CON0_POL_BIT];
  assign rise_hit = result & ~result_prev & con1_i[CON1_RISE_BIT];
  assign fall_hit = ~result & result_prev & con1_i[CON1_FALL_BIT];

  // Result bit, edge memory and sticky flag
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_o    <= 1'b0;
      result_prev <= 1'b0;
      irq_flag_o  <= 1'b0;
    end else if (clk_en_i) begin
      result_o    <= result;
      result_prev <= result;
      if (rise_hit || fall_hit) begin
        irq_flag_o <= 1'b1;
      end else if (flag_clr_i) begin
        irq_flag_o <= 1'b0;
      end
    end
  end

  // Output to timer and pin, gated by timer clock fall in sync mode
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_out_o <= 1'b0;
    end else if (clk_en_i) begin
      if (!con0_i[CON0_SYNC_BIT] || (tmr_prev && !tmr_sync[1])) begin
        sync_out_o <= result;
      end
    end
  end
endmodule

// *** tb/cmpc_checker.sv ***
`timescale 1ns/1ps
// Port-level checks on the register bank
module cmpc_checker
  import cmpc_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        clk_en_i,
  input wire logic [4:0]  addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  input wire logic [1:0]  raw_i,
  input wire logic        tmr_clk_i,
  input wire logic [1:0]  enable_o,
  input wire logic [1:0]  hyst_o,
  input wire logic [11:0] neg_route_o,
  input wire logic [9:0]  pos_route_o,
  input wire logic [1:0]  sync_out_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Read data only in the cycle after a read strobe
  AST_RD_QUIET: assert property (rdata_o != 8'h00 |-> $past(rd_i))
    else $error("read data outside a read cycle");
  AST_NEG_ONEHOT: assert property ($onehot0(neg_route_o[5:0]))
    else $error("negative route not one-hot");
  AST_POS_ONEHOT: assert property ($onehot0(pos_route_o[4:0]))
    else $error("positive route not one-hot");
  AST_NEG_GND: assert property (wr_i && addr_i == OFF_NSEL && wdata_i[2:0] == 3'h7
    |-> ##[1:2] neg_route_o[5:0] == 6'h20) else $error("ground code not routed");
  AST_POS_DAC: assert property (wr_i && addr_i == OFF_PSEL && wdata_i[2:0] == 3'h5
    |-> ##[1:2] pos_route_o[4:0] == 5'h04) else $error("converter code not routed");
  AST_MIRROR_HI: assert property (rd_i && addr_i == OFF_MIRROR |=> rdata_o[7:2] == 6'h00)
    else $error("mirror upper bits not zero");
  AST_SEL_HI: assert property (rd_i && (addr_i == OFF_NSEL || addr_i == OFF_PSEL)
    |=> rdata_o[7:3] == 5'h00) else $error("select upper bits not zero");
  AST_CON1_HI: assert property (rd_i && addr_i == OFF_CON1 |=> rdata_o[7:2] == 6'h00)
    else $error("edge enable upper bits not zero");
  AST_IRQ_HOLD: assert property ($fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2))
    else $error("interrupt dropped without a write");
endmodule

bind cmpc_regs cmpc_checker u_chk (.ref_clk_i, .rst_n_i, .clk_en_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .raw_i, .tmr_clk_i, .enable_o, .hyst_o, .neg_route_o, .pos_route_o,
  .sync_out_o, .irq_o);

// *** tb/cmpc_core_model.sv ***
`timescale 1ns/1ps
// Analog core: routed positive level high and routed negative level low
module cmpc_core_model (
  input  wire logic [11:0] neg_route_i,
  input  wire logic [9:0]  pos_route_i,
  input  wire logic [4:0]  pin_pos_i,
  input  wire logic [5:0]  pin_neg_i,
  output logic [1:0]       raw_o
);
  // Unconnected inputs read as low
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      raw_o[k] = |(pos_route_i[k*5 +: 5] & pin_pos_i) & ~|(neg_route_i[k*6 +: 6] & pin_neg_i);
    end
  end
endmodule

// *** tb/cmpc_regs_tb_top.sv ***
`timescale 1ns/1ps
module cmpc_regs_tb_top;
  import cmpc_pkg::*;
  logic        ref_clk_i, rst_n_i, clk_en_i, wr_i, rd_i, tmr_clk_i, irq_o;
  logic [4:0]  addr_i, pin_pos;
  logic [7:0]  wdata_i, rdata_o;
  logic [1:0]  raw_i, enable_o, hyst_o, sync_out_o;
  logic [11:0] neg_route_o;
  logic [9:0]  pos_route_o;
  logic [5:0]  pin_neg;
  int          n_fail = 0;
  int          samples_checked = 0;
  cmpc_regs u_dut (.ref_clk_i, .rst_n_i, .clk_en_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .raw_i, .tmr_clk_i, .enable_o, .hyst_o, .neg_route_o, .pos_route_o, .sync_out_o, .irq_o);
  cmpc_core_model u_core (.neg_route_i(neg_route_o), .pos_route_i(pos_route_o),
    .pin_pos_i(pin_pos), .pin_neg_i(pin_neg), .raw_o(raw_i));
  always #5 ref_clk_i = ~ref_clk_i;
  // Bus write, one strobe cycle
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  // Bus read and compare in the following cycle
  task automatic chk_reg(input logic [4:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    samples_checked++;
    if (rdata_o !== e) begin
      n_fail++;
      $display("CHECK FAILED reg %h expected %h seen %h", a, e, rdata_o);
    end
  endtask
  task automatic chk_port(input string s, input logic [11:0] e, input logic [11:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic settle;
    repeat (6) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic drive_pin(input logic v);
    @(posedge ref_clk_i);
    pin_pos[0] <= v;
    settle;
  endtask
  function automatic logic [5:0] neg_exp(input int c);
    if (c < 4) return 6'h01 << c;
    return (c == 7) ? 6'h20 : (c == 6) ? 6'h10 : 6'h00;
  endfunction
  function automatic logic [4:0] pos_exp(input int c);
    if (c < 2) return 5'h01 << c;
    return (c == 7) ? 5'h10 : (c == 6) ? 5'h08 : (c == 5) ? 5'h04 : 5'h00;
  endfunction
  task automatic print_verdict;
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (4000) @(posedge ref_clk_i);
    n_fail++;
    print_verdict;
  end
  // Main sequence
  initial begin
    {ref_clk_i, rst_n_i, wr_i, rd_i, addr_i, wdata_i, pin_pos, pin_neg} = '0;
    clk_en_i = 1'b1;
    tmr_clk_i = 1'b1;
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 8; a++) chk_reg(a[4:0], 8'h00);
    chk_port("neg route", 12'h041, neg_route_o);
    chk_port("pos route", 12'h021, {2'b00, pos_route_o});
    wr(OFF_CON1, 8'hFF);
    wr(OFF_NSEL, 8'hFF);
    wr(OFF_PSEL, 8'hFF);
    wr(OFF_MIRROR, 8'hFF);
    wr(5'h1F, 8'hFF);
    chk_reg(OFF_CON1, 8'h03);
    chk_reg(OFF_NSEL, 8'h07);
    chk_reg(OFF_PSEL, 8'h07);
    chk_reg(OFF_MIRROR, 8'h00);
    chk_reg(5'h1F, 8'h00);
    wr(OFF_CON1, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(OFF_NSEL, 8'(c));
      wr(OFF_PSEL, 8'(c));
      settle;
      chk_port("neg route", {6'h00, neg_exp(c)}, {6'h00, neg_route_o[5:0]});
      chk_port("pos route", {7'h00, pos_exp(c)}, {7'h00, pos_route_o[4:0]});
    end
    // Pin 0 steers both results
    wr(OFF_PSEL, 8'h00);
    wr(OFF_NSEL, 8'h07);
    wr(OFF_IRQ_MASK, 8'h03);
    drive_pin(1'b1);
    chk_reg(OFF_IRQ_STATUS, 8'h00);
    chk_reg(OFF_MIRROR, 8'h03);
    drive_pin(1'b0);
    wr(OFF_CON1, 8'h02);
    drive_pin(1'b1);
    chk_reg(OFF_IRQ_STATUS, 8'h01);
    chk_port("irq", 12'h001, {11'h000, irq_o});
    wr(OFF_IRQ_STATUS, 8'h01);
    drive_pin(1'b0);
    chk_reg(OFF_IRQ_STATUS, 8'h00);
    chk_port("irq", 12'h000, {11'h000, irq_o});
    wr(OFF_CON1, 8'h01);
    drive_pin(1'b1);
    chk_reg(OFF_IRQ_STATUS, 8'h00);
    drive_pin(1'b0);
    chk_reg(OFF_IRQ_STATUS, 8'h01);
    wr(OFF_IRQ_MASK, 8'h00);
    settle;
    chk_port("irq", 12'h000, {11'h000, irq_o});
    wr(OFF_IRQ_STATUS, 8'h01);
    // Comparator 2 left unconnected shows bit order
    wr(CMP_STRIDE + OFF_PSEL, 8'h04);
    drive_pin(1'b1);
    chk_reg(OFF_MIRROR, 8'h01);
    wr(OFF_CON0, 8'h10);
    settle;
    chk_reg(OFF_MIRROR, 8'h00);
    // Sync mode follows only timer clock falls
    wr(OFF_CON0, 8'h01);
    tmr_clk_i <= 1'b0;
    settle;
    @(posedge ref_clk_i);
    tmr_clk_i <= 1'b1;
    drive_pin(1'b0);
    chk_port("sync out", 12'h001, {11'h000, sync_out_o[0]});
    @(posedge ref_clk_i);
    tmr_clk_i <= 1'b0;
    settle;
    chk_port("sync out", 12'h000, {11'h000, sync_out_o[0]});
    // Enabled edge in the clear cycle keeps the flag
    drive_pin(1'b1);
    wr(OFF_IRQ_STATUS, 8'h01);
    @(posedge ref_clk_i);
    pin_pos[0] <= 1'b0;
    @(posedge ref_clk_i);
    wr(OFF_IRQ_STATUS, 8'h01);
    settle;
    chk_reg(OFF_IRQ_STATUS, 8'h01);
    // Comparator 2 control: mask, read-back, analog enables, mirror bit 1
    wr(CMP_STRIDE + OFF_CON0, 8'hFF);
    settle;
    chk_reg(CMP_STRIDE + OFF_CON0, 8'hD3);
    chk_port("enable", 12'h002, {10'h000, enable_o});
    chk_port("hyst", 12'h002, {10'h000, hyst_o});
    chk_reg(OFF_MIRROR, 8'h02);
    chk_port("sync out", 12'h000, {11'h000, sync_out_o[1]});
    @(posedge ref_clk_i);
    tmr_clk_i <= 1'b1;
    settle;
    @(posedge ref_clk_i);
    tmr_clk_i <= 1'b0;
    settle;
    chk_port("sync out", 12'h002, {10'h000, sync_out_o});
    // Reset in mid-run clears both comparators' control fields again
    @(posedge ref_clk_i);
    rst_n_i <= 1'b0;
    @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 8; a++) chk_reg(a[4:0], 8'h00);
    chk_port("neg route", 12'h041, neg_route_o);
    chk_port("enable", 12'h000, {10'h000, enable_o});
    chk_port("hyst", 12'h000, {10'h000, hyst_o});
    print_verdict;
  end
endmodule
